// ---- core/led_ctrl_pkg.sv ----
/*
  Shared constants and types of the LED brightness control logic:
  sub-address map, field positions, reset values, pump timing, states.
  Assumes a single 20 MHz system clock; the pump clock is an enable.
*/
package led_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ  = 20000000;
  localparam int unsigned PUMP_CLK_HZ = 850000;
  // Pump tick period in system cycles, rounded down (23)
  localparam int unsigned PUMP_DIV    = SYS_CLK_HZ / PUMP_CLK_HZ;
  localparam logic [4:0]  PUMP_DIV_LAST = 5'(PUMP_DIV - 1);

  // ----------------------------------------------------------------
  // Serial port map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h1B; // arbitrary
  localparam logic [7:0] SUB_PRIMARY   = 8'h00;
  localparam logic [7:0] SUB_FLASH     = 8'h01;
  localparam logic [7:0] SUB_CTRL      = 8'h02;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Field positions inside the flash and control bytes
  localparam int unsigned FLASH_HI_LSB  = 4;
  localparam int unsigned FLASH_LO_LSB  = 0;
  localparam int unsigned CTRL_IND_LSB  = 0;
  localparam int unsigned CTRL_GPO_EN   = 2;
  localparam int unsigned CTRL_GPO_LVL  = 3;
  localparam int unsigned CTRL_FSEL_HI  = 4;
  localparam int unsigned CTRL_PIN_MODE = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] primary;
    logic [3:0] flash_hi;
    logic [3:0] flash_lo;
    logic [1:0] ind;
    logic       gpo_en;
    logic       gpo_lvl;
    logic       fsel_hi;
    logic       pin_mode;
  } bank_t;

  localparam bank_t BANK_RST = '0;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       valid;
    logic [7:0] data;
  } rx_evt_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_ADDR = 3'b010,
    RX_DATA = 3'b100
  } rx_state_t;

  typedef enum logic [2:0] {
    PUMP_1X  = 3'b001,
    PUMP_1P5 = 3'b010,
    PUMP_2X  = 3'b100
  } pump_state_t;

  localparam logic [1:0] PUMP_CODE_1X  = 2'h0;
  localparam logic [1:0] PUMP_CODE_1P5 = 2'h1;
  localparam logic [1:0] PUMP_CODE_2X  = 2'h2;

  // Pump state to the two-bit code the analog pump expects
  function automatic logic [1:0] pump_code(input pump_state_t s);
    case (s)
      PUMP_1P5: pump_code = PUMP_CODE_1P5;
      PUMP_2X:  pump_code = PUMP_CODE_2X;
      default:  pump_code = PUMP_CODE_1X;
    endcase
  endfunction

endpackage

// ---- core/serial_write_rx.sv ----
/*
  Write-only two-wire serial receiver: start/stop detection, address
  match, byte shifting and acknowledge drive.
  Assumes SCL and SDA already pass two synchronising flip-flops.
*/
`timescale 1ns/1ps
module serial_write_rx
  import led_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clr_i,
  // Synchronised line levels and device address
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [6:0] dev_addr_i,
  // Events and acknowledge drive
  output rx_evt_t         evt_o,
  output logic            sda_oe_o
);

  logic      scl_q;
  logic      sda_q;
  rx_state_t st_r;
  logic [3:0] cnt_r;
  logic [6:0] sh_r;
  logic      want_r;
  logic      ackd_r;

  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start    = scl_i & scl_q & sda_q & ~sda_i;
  wire stop     = scl_i & scl_q & ~sda_q & sda_i;

  // ----------------------------------------------------------------
  // Line history for edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  // One bit taken per SCL rise; the ninth clock is the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      st_r     <= RX_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 7'h00;
      want_r   <= 1'b0;
      ackd_r   <= 1'b0;
      sda_oe_o <= 1'b0;
      evt_o    <= '0;
    end else begin
      evt_o.start <= start;
      evt_o.stop  <= stop;
      evt_o.valid <= 1'b0;
      if (start) begin
        st_r     <= RX_ADDR;
        cnt_r    <= 4'h0;
        ackd_r   <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop) begin
        st_r     <= RX_IDLE;
        cnt_r    <= 4'h0;
        ackd_r   <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (scl_rise && cnt_r != BITS_PER_BYTE
                   && st_r != RX_IDLE) begin
        sh_r  <= {sh_r[5:0], sda_i};
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == BITS_PER_BYTE - 4'h1) begin
          case (st_r)
            RX_ADDR: want_r <= (sh_r == dev_addr_i) && !sda_i;
            default: begin
              want_r       <= 1'b1;
              evt_o.valid  <= 1'b1;
              evt_o.data   <= {sh_r, sda_i};
            end
          endcase
        end
      end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
        if (!ackd_r) begin
          ackd_r   <= 1'b1;
          sda_oe_o <= want_r;
        end else begin
          ackd_r   <= 1'b0;
          sda_oe_o <= 1'b0;
          cnt_r    <= 4'h0;
          case (st_r)
            RX_ADDR: st_r <= want_r ? RX_DATA : RX_IDLE;
            default: st_r <= st_r;
          endcase
        end
      end
    end
  end

endmodule

// ---- core/led_brightness_ctrl_regs.sv ----
/*
  Control logic of a multi-display LED driver: serial-written holding
  bank, load into active codes, flash level select, charge-pump mode.
  Assumes all pins are asynchronous to CLK_I and the analog side reads
  the registered codes; dropout sense comes in as a level.
*/
// Behaviour
// - Hold an 8-bit primary bank code, 256 linear steps, all outputs.
// - Primary code zero disables every primary output.
// - Hold a 2-bit indicator code, four steps including off.
// - Indicator pin also usable as serially set general output.
// - Indicator has no dropout sense and never steps the pump up.
// - Logic supply undervoltage forces every register bit to zero.
// - Two 4-bit flash codes, high and low, 16 linear steps each.
// - Flash code chosen from serial setting or level-select pin.
// - Pin high applies the high flash code, low applies the low.
// - Each falling edge of level-select returns pump to 1x.
// - Applied flash code zero disables the flash bank.
// - Host gives one bit per serial clock; one bit shifted each.
// - Pump starts 1x; first dropout gives 1.5x, next gives 2x.
// - Any serially updated brightness bit returns pump to 1x.
// - Serial data taken most significant bit first.
// - Load pulse after stop copies holding bank into active bank.
`timescale 1ns/1ps
module led_brightness_ctrl_regs
  import led_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
)(
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // Serial port pins
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // Other pins and analog sense
  input  wire logic       LEVEL_SEL_I,
  input  wire logic       UNDERVOLTAGE_LOCKOUT_I,
  input  wire logic       DROPOUT_I,
  // Primary bank
  output logic [7:0]      PRIMARY_CODE_O,
  output logic            PRIMARY_EN_O,
  // Flashlight bank
  output logic [3:0]      FLASH_CODE_O,
  output logic            FLASH_EN_O,
  // Indicator
  output logic [1:0]      IND_CODE_O,
  output logic            GPO_EN_O,
  output logic            GPO_LEVEL_O,
  // Charge pump
  output logic [1:0]      PUMP_MODE_O
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit order: 0 SCL, 1 SDA, 2 level select, 3 lockout, 4 dropout
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       lvl_q;
  logic       drop_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      meta_r <= 5'h03;
      sync_r <= 5'h03;
    end else begin
      meta_r <= {DROPOUT_I, UNDERVOLTAGE_LOCKOUT_I, LEVEL_SEL_I, SDA_I, SCL_I};
      sync_r <= meta_r;
    end
  end

  wire scl_s  = sync_r[0];
  wire sda_s  = sync_r[1];
  wire lvl_s  = sync_r[2];
  wire undervoltage_lockout_s = sync_r[3];
  wire drop_s = sync_r[4];
  wire clr    = undervoltage_lockout_s;

  // Edge history of level select and dropout
  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      lvl_q  <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      lvl_q  <= lvl_s;
      drop_q <= drop_s;
    end
  end

  wire lvl_fall  = lvl_q & ~lvl_s;
  wire drop_rise = drop_s & ~drop_q;

  // ----------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------
  rx_evt_t evt;
  logic    oe_rx;

  serial_write_rx u_rx (
    .clk_i      (CLK_I),
    .rst_i      (RST_I),
    .clr_i      (clr),
    .scl_i      (scl_s),
    .sda_i      (sda_s),
    .dev_addr_i (DEV_ADDR),
    .evt_o      (evt),
    .sda_oe_o   (oe_rx)
  );

  // Open-drain: only ever pulls low
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
    end
  end

  assign SDA_OE_O = oe_rx;

  // ----------------------------------------------------------------
  // Holding bank
  // ----------------------------------------------------------------
  bank_t      hold_r;
  bank_t      act_r;
  logic [7:0] sub_r;
  logic       have_sub_r;
  logic       wrote_r;
  logic       load_r;

  // Merge one data byte into the bank at a sub-address
  function automatic bank_t put_byte(input bank_t b, input logic [7:0] s,
                                     input logic [7:0] d);
    bank_t r;
    r = b;
    if (s == SUB_PRIMARY) begin
      r.primary = d;
    end else if (s == SUB_FLASH) begin
      r.flash_hi = d[FLASH_HI_LSB +: 4];
      r.flash_lo = d[FLASH_LO_LSB +: 4];
    end else if (s == SUB_CTRL) begin
      r.ind      = d[CTRL_IND_LSB +: 2];
      r.gpo_en   = d[CTRL_GPO_EN];
      r.gpo_lvl  = d[CTRL_GPO_LVL];
      r.fsel_hi  = d[CTRL_FSEL_HI];
      r.pin_mode = d[CTRL_PIN_MODE];
    end
    put_byte = r;
  endfunction

  // First byte after the address picks the register, then increments
  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      hold_r     <= BANK_RST;
      sub_r      <= 8'h00;
      have_sub_r <= 1'b0;
      wrote_r    <= 1'b0;
    end else if (evt.start) begin
      have_sub_r <= 1'b0;
      wrote_r    <= 1'b0;
    end else if (evt.valid) begin
      if (!have_sub_r) begin
        sub_r      <= evt.data;
        have_sub_r <= 1'b1;
      end else begin
        hold_r  <= put_byte(hold_r, sub_r, evt.data);
        sub_r   <= sub_r + 8'h01;
        wrote_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Load into the active bank
  // ----------------------------------------------------------------
  // Only a stop that ends a write with data produces a load
  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      load_r <= 1'b0;
    end else begin
      load_r <= evt.stop & wrote_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      act_r <= BANK_RST;
    end else if (load_r) begin
      act_r <= hold_r;
    end
  end

  // Brightness change carried by this load
  wire bright_upd = load_r &&
       ({hold_r.primary, hold_r.flash_hi, hold_r.flash_lo, hold_r.ind}
     != {act_r.primary, act_r.flash_hi, act_r.flash_lo, act_r.ind});

  // ----------------------------------------------------------------
  // Flash level selection and bank outputs
  // ----------------------------------------------------------------
  logic [3:0] flash_sel;

  always_comb begin
    if (act_r.pin_mode) begin
      flash_sel = lvl_s ? act_r.flash_hi : act_r.flash_lo;
    end else begin
      flash_sel = act_r.fsel_hi ? act_r.flash_hi
                                : act_r.flash_lo;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      PRIMARY_CODE_O <= 8'h00;
      PRIMARY_EN_O   <= 1'b0;
      FLASH_CODE_O   <= 4'h0;
      FLASH_EN_O     <= 1'b0;
      IND_CODE_O     <= 2'h0;
      GPO_EN_O       <= 1'b0;
      GPO_LEVEL_O    <= 1'b0;
    end else begin
      PRIMARY_CODE_O <= act_r.primary;
      PRIMARY_EN_O   <= act_r.primary != 8'h00;
      FLASH_CODE_O   <= flash_sel;
      FLASH_EN_O     <= flash_sel != 4'h0;
      IND_CODE_O     <= act_r.ind;
      GPO_EN_O       <= act_r.gpo_en;
      GPO_LEVEL_O    <= act_r.gpo_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Charge-pump mode
  // ----------------------------------------------------------------
  // Dropout only counts while a primary or flash source is enabled;
  // the indicator takes no part, so it never steps the pump up.
  pump_state_t pump_r;
  wire         src_on   = PRIMARY_EN_O | FLASH_EN_O;
  wire         pump_clr = bright_upd | lvl_fall;

  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      pump_r <= PUMP_1X;
    end else if (pump_clr) begin
      pump_r <= PUMP_1X;
    end else if (drop_rise && src_on) begin
      case (pump_r)
        PUMP_1X:  pump_r <= PUMP_1P5;
        PUMP_1P5: pump_r <= PUMP_2X;
        default:  pump_r <= PUMP_2X;
      endcase
    end
  end

  // Pump clock enable; the pump only sees new modes on its own tick
  logic [4:0] div_r;
  logic       tick_r;

  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      div_r  <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= div_r == PUMP_DIV_LAST;
      div_r  <= (div_r == PUMP_DIV_LAST) ? 5'h00 : div_r + 5'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I || clr) begin
      PUMP_MODE_O <= PUMP_CODE_1X;
    end else if (tick_r) begin
      PUMP_MODE_O <= pump_code(pump_r);
    end
  end

endmodule

// ---- test/i2c_host_model.sv ----
/*
  Serial host that writes the LED control block over two wires.
  Assumes the bench forms the wired data level and feeds it back.
*/
`timescale 1ns/1ps
module i2c_host_model (
  // Wire drive, 1 releases
  output logic      scl_o,
  output logic      sda_o,
  // Wired data level
  input  wire logic line_i
);
  // Clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ------------------------------------------------------------
  // Bus conditions and bytes, 400 ns serial period
  // ------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #100 scl_o = 1'b1;
      #200 scl_o = 1'b0;
      #100;
    end
    sda_o = 1'b1;
    #100 scl_o = 1'b1;
    #100 ack = !line_i;
    #100 scl_o = 1'b0;
    #100;
  endtask

  // Start also serves as repeated start
  task automatic write_regs(input logic [6:0] addr, input logic [7:0] sub,
                            input logic [7:0] d[$], output logic ack);
    logic a;
    sda_o = 1'b1;
    #100 scl_o = 1'b1;
    #100 sda_o = 1'b0;
    #100 scl_o = 1'b0;
    send_byte({addr, 1'b0}, ack);
    if (ack) begin
      send_byte(sub, a);
      foreach (d[i]) send_byte(d[i], a);
    end
    sda_o = 1'b0;
    #100 scl_o = 1'b1;
    #100 sda_o = 1'b1;
    #200;
  endtask
endmodule

// ---- test/led_brightness_ctrl_regs_monitor.sv ----
/*
  Concurrent checks on the LED control block's pins.
  Assumes it is bound to the top module; inputs named as its ports.
*/
`timescale 1ns/1ps
module led_brightness_ctrl_regs_monitor (
  // Clock and reset
  input wire logic       CLK_I,
  input wire logic       RST_I,
  // Pins watched
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O,
  input wire logic       LEVEL_SEL_I,
  input wire logic       UNDERVOLTAGE_LOCKOUT_I,
  input wire logic [7:0] PRIMARY_CODE_O,
  input wire logic       PRIMARY_EN_O,
  input wire logic [3:0] FLASH_CODE_O,
  input wire logic       FLASH_EN_O,
  input wire logic [1:0] IND_CODE_O,
  input wire logic       GPO_EN_O,
  input wire logic       GPO_LEVEL_O,
  input wire logic [1:0] PUMP_MODE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ------------------------------------------------------------
  // Enables, pump and serial port
  // ------------------------------------------------------------
  prim_en_a: assert property (
    PRIMARY_EN_O == (PRIMARY_CODE_O != 8'h00))
    else $error("primary enable disagrees with code");
  flash_en_a: assert property (
    FLASH_EN_O == (FLASH_CODE_O != 4'h0))
    else $error("flash enable disagrees with code");
  pump_legal_a: assert property (
    PUMP_MODE_O != 2'h3)
    else $error("pump mode code out of range");
  // Pump tick is 23 cycles, so no two changes within 8
  pump_hold_a: assert property (
    !UNDERVOLTAGE_LOCKOUT_I && $changed(PUMP_MODE_O) |=> $stable(PUMP_MODE_O)[*8])
    else $error("pump mode changed off the pump tick");
  level_fall_a: assert property (
    $fell(LEVEL_SEL_I) |-> ##[1:28] PUMP_MODE_O == 2'h0)
    else $error("pump not back to 1x after level fall");
  start_1x_a: assert property (
    $fell(RST_I) |-> PUMP_MODE_O == 2'h0 && !PRIMARY_EN_O)
    else $error("pump not 1x after reset");
  undervoltage_lockout_clear_a: assert property (
    UNDERVOLTAGE_LOCKOUT_I[*6] |-> PRIMARY_CODE_O == 8'h00 && IND_CODE_O == 2'h0 &&
    FLASH_CODE_O == 4'h0 && !GPO_EN_O && !GPO_LEVEL_O)
    else $error("registers not cleared under low supply");
  ack_len_a: assert property (
    $rose(SDA_OE_O) |=> (SDA_OE_O && !SDA_O)[*6])
    else $error("acknowledge too short");
endmodule

bind led_brightness_ctrl_regs led_brightness_ctrl_regs_monitor mon (
  .CLK_I(CLK_I), .RST_I(RST_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .LEVEL_SEL_I(LEVEL_SEL_I), .UNDERVOLTAGE_LOCKOUT_I(UNDERVOLTAGE_LOCKOUT_I),
  .PRIMARY_CODE_O(PRIMARY_CODE_O), .PRIMARY_EN_O(PRIMARY_EN_O),
  .FLASH_CODE_O(FLASH_CODE_O), .FLASH_EN_O(FLASH_EN_O),
  .IND_CODE_O(IND_CODE_O), .GPO_EN_O(GPO_EN_O),
  .GPO_LEVEL_O(GPO_LEVEL_O), .PUMP_MODE_O(PUMP_MODE_O)
);

// ---- test/led_brightness_ctrl_regs_tb.sv ----
/*
  Self-checking bench for the LED control block.
  Assumes the host model drives the serial pins; data has a pull-up.
*/
`timescale 1ns/1ps
module led_brightness_ctrl_regs_tb;
  import led_ctrl_pkg::*;
  logic       CLK_I = 1'b0;
  logic       RST_I = 1'b1;
  logic       LEVEL_SEL_I = 1'b0;
  logic       UNDERVOLTAGE_LOCKOUT_I = 1'b0;
  logic       DROPOUT_I = 1'b0;
  logic       scl, host_sda, sda_line, ack, SDA_O, SDA_OE_O;
  logic       PRIMARY_EN_O, FLASH_EN_O, GPO_EN_O, GPO_LEVEL_O;
  logic [7:0] PRIMARY_CODE_O;
  logic [3:0] FLASH_CODE_O;
  logic [1:0] IND_CODE_O, PUMP_MODE_O;
  int         mismatches = 0;
  int         checked = 0;

  // Wired-AND data line with pull-up
  assign sda_line = host_sda & !(SDA_OE_O && !SDA_O);
  always #25 CLK_I = ~CLK_I;

  i2c_host_model host (.scl_o(scl), .sda_o(host_sda), .line_i(sda_line));

  led_brightness_ctrl_regs dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .LEVEL_SEL_I(LEVEL_SEL_I),
    .UNDERVOLTAGE_LOCKOUT_I(UNDERVOLTAGE_LOCKOUT_I), .DROPOUT_I(DROPOUT_I),
    .PRIMARY_CODE_O(PRIMARY_CODE_O), .PRIMARY_EN_O(PRIMARY_EN_O),
    .FLASH_CODE_O(FLASH_CODE_O), .FLASH_EN_O(FLASH_EN_O),
    .IND_CODE_O(IND_CODE_O), .GPO_EN_O(GPO_EN_O),
    .GPO_LEVEL_O(GPO_LEVEL_O), .PUMP_MODE_O(PUMP_MODE_O)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always change 2 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_I);
    #2;
  endtask

  // Load lands a few cycles after stop, so settle before looking
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    host.write_regs(DEV_ADDR_DFLT, sub, d, ack);
    check(8'(ack), 8'h01);
    tick(8);
  endtask

  task automatic dropout();
    DROPOUT_I = 1'b1;
    tick(4);
    DROPOUT_I = 1'b0;
    tick(4);
  endtask

  task automatic pump_is(input logic [1:0] exp);
    int n;
    n = 0;
    while (PUMP_MODE_O !== exp && n < 60) begin
      tick(1);
      n++;
    end
    // A wait that runs out fails the run at once
    if (PUMP_MODE_O !== exp) begin
      mismatches++;
      $display("Error at %0t: pump mode wait ran out", $time);
      finish_test();
    end else begin
      check(8'(PUMP_MODE_O), 8'(exp));
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_primary();
    wr(SUB_PRIMARY, '{8'h80});
    check(PRIMARY_CODE_O, 8'h80);
    check(8'(PRIMARY_EN_O), 8'h01);
    wr(SUB_PRIMARY, '{8'h01});
    check(PRIMARY_CODE_O, 8'h01);
    // Foreign address gets no acknowledge and loads nothing
    host.write_regs(DEV_ADDR_DFLT ^ 7'h01, SUB_PRIMARY, '{8'h22}, ack);
    tick(8);
    check(8'(ack), 8'h00);
    check(PRIMARY_CODE_O, 8'h01);
    wr(SUB_PRIMARY, '{8'h00});
    check(8'(PRIMARY_EN_O), 8'h00);
    $display("t_primary done");
  endtask

  task automatic t_flash();
    wr(SUB_FLASH, '{8'hA5, 8'h00});
    check(8'(FLASH_CODE_O), 8'h05);
    wr(SUB_CTRL, '{8'h10});
    check(8'(FLASH_CODE_O), 8'h0A);
    wr(SUB_CTRL, '{8'h20});
    LEVEL_SEL_I = 1'b1;
    tick(6);
    check(8'(FLASH_CODE_O), 8'h0A);
    LEVEL_SEL_I = 1'b0;
    tick(6);
    check(8'(FLASH_CODE_O), 8'h05);
    wr(SUB_FLASH, '{8'hA0});
    check(8'(FLASH_EN_O), 8'h00);
    $display("t_flash done");
  endtask

  // Control byte i*5 sets indicator i and both output bits to i
  task automatic t_ind();
    for (int i = 0; i < 4; i++) begin
      wr(SUB_CTRL, '{8'(i * 5)});
      check(8'(IND_CODE_O), 8'(i));
      check(8'({GPO_LEVEL_O, GPO_EN_O}), 8'(i));
    end
    $display("t_ind done");
  endtask

  task automatic t_pump();
    wr(SUB_PRIMARY, '{8'h40});
    dropout();
    pump_is(2'h1);
    dropout();
    pump_is(2'h2);
    dropout();
    tick(30);
    check(8'(PUMP_MODE_O), 8'h02);
    wr(SUB_PRIMARY, '{8'h41});
    pump_is(2'h0);
    dropout();
    pump_is(2'h1);
    LEVEL_SEL_I = 1'b1;
    tick(4);
    LEVEL_SEL_I = 1'b0;
    pump_is(2'h0);
    // Only the indicator lit: its state must not step the pump
    wr(SUB_PRIMARY, '{8'h00});
    dropout();
    tick(30);
    check(8'(PUMP_MODE_O), 8'h00);
    $display("t_pump done");
  endtask

  task automatic t_undervoltage_lockout();
    wr(SUB_PRIMARY, '{8'h33});
    check(PRIMARY_CODE_O, 8'h33);
    UNDERVOLTAGE_LOCKOUT_I = 1'b1;
    tick(8);
    UNDERVOLTAGE_LOCKOUT_I = 1'b0;
    tick(4);
    check(PRIMARY_CODE_O, 8'h00);
    check(8'({IND_CODE_O, GPO_EN_O, GPO_LEVEL_O}), 8'h00);
    $display("t_undervoltage_lockout done");
  endtask

  initial begin
    tick(4);
    RST_I = 1'b0;
    tick(3);
    t_primary();
    t_flash();
    t_ind();
    t_pump();
    t_undervoltage_lockout();
    finish_test();
  end
endmodule
